// ==== pkg/rx_pcs_pkg.sv ====
// package: constants and types for the receive pcs status block
// assumes: single pclk domain, apb register access
package rx_pcs_pkg;
  localparam logic [7:0] ctrl_off   = 8'h00;
  localparam logic [7:0] status_off = 8'h04;
  localparam logic [7:0] irq_off    = 8'h08;
  localparam logic [7:0] mask_off   = 8'h0C;
  localparam logic [7:0] rlvth_off  = 8'h10;
  localparam logic [7:0] rmlvl_off  = 8'h14;
  localparam logic [7:0] pat_off    = 8'h18;
  // control register fields
  localparam int c_mode_lo  = 0;
  localparam int c_ratematch = 2;
  localparam int c_bonded   = 3;
  localparam int c_corerd   = 4;
  localparam int c_bytedes  = 5;
  localparam int c_width10  = 6;
  // interrupt bits
  localparam int i_found  = 0;
  localparam int i_rlv    = 1;
  localparam int i_full   = 2;
  localparam int i_empty  = 3;
  localparam int i_ins    = 4;
  localparam int i_del    = 5;
  localparam int n_irq    = 6;
  localparam logic [31:0] ctrl_rst  = 32'h0000_0040;
  localparam logic [31:0] rlvth_rst = 32'h0000_0010;
  localparam logic [31:0] pat_rst   = 32'h0000_017C;
  localparam logic [31:0] rmlvl_rst = 32'h0000_0000;
  localparam logic [1:0] hold_nobd = 2'h2;
  localparam logic [1:0] hold_bd   = 2'h3;
  localparam real clk_ns = 4.0;
  typedef enum logic [1:0] {align_auto, align_manual, align_bitslip} align_mode_t;
  typedef enum logic [1:0] {dom_rec, dom_tx, dom_core, dom_rdclk} out_dom_t;
  typedef enum {al_search, al_locked} al_state_t;
endpackage

// ==== rtl/rx_pcs_align_ratematch_status.sv ====
// file: receive pcs word alignment, polarity, run-length and rate-match status
// assumes: apb master on pclk; data word and async controls come from fabric/pins
`timescale 1ns/1ps
`default_nettype none
module rx_pcs_align_ratematch_status #(
  parameter int W = 10
) (
  // apb
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // receive datapath
  input  wire logic [W-1:0] rx_word_in,
  input  wire logic         rx_word_valid,
  input  wire logic         rx_is_ctrl_in,
  input  wire logic         rm_insert_ev,
  input  wire logic         rm_delete_ev,
  input  wire logic         rm_full_in,
  input  wire logic         rm_empty_in,
  // async fabric controls
  input  wire logic         bitslip_req,
  input  wire logic         polarity_inv,
  input  wire logic         manual_align_enable_in,
  // status
  output logic [W-1:0]      aligned_word,
  output logic              align_locked,
  output logic              pattern_found_flag,
  output logic              run_length_viol,
  output logic              ratematch_insert_flag,
  output logic              ratematch_delete_flag,
  output logic              ratematch_full,
  output logic              ratematch_empty,
  output logic              ctrl_group_flag,
  output logic [1:0]        align_status_dom,
  output logic [1:0]        ratematch_dom,
  output logic              irq
);
  if (W != 10 && W != 8) begin : g_bad_w
    $error("W must be 8 or 10");
  end

  logic [31:0] ctrl_q, rlvth_q, pat_q;
  localparam int n_irq_w = rx_pcs_pkg::n_irq;
  logic [n_irq_w-1:0] irq_st_q, mask_q;
  logic acc;
  assign acc = psel && penable;

  // synchronisers: stage 1 read only by stage 2
  logic [2:0] s1_q, s2_q, s3_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q <= 3'h0;
      s2_q <= 3'h0;
      s3_q <= 3'h0;
    end else begin
      s1_q <= {manual_align_enable_in, polarity_inv, bitslip_req};
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end
  logic [2:0] ctl_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ctl_q <= 3'h0;
    else begin
      for (int i = 0; i < 3; i++) begin
        if (s2_q[i] == s3_q[i]) ctl_q[i] <= s3_q[i];
      end
    end
  end
  logic slip_prev_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) slip_prev_q <= 1'b0;
    else slip_prev_q <= ctl_q[0];
  end

  rx_pcs_pkg::align_mode_t mode;
  assign mode = rx_pcs_pkg::align_mode_t'(ctrl_q[rx_pcs_pkg::c_mode_lo +: 2]);
  logic slip_rise;
  assign slip_rise = ctl_q[0] && !slip_prev_q && mode == rx_pcs_pkg::align_bitslip;

  // polarity inversion and word assembly
  logic [W-1:0] inv_word;
  assign inv_word = ctl_q[1] ? ~rx_word_in : rx_word_in;
  logic [W-1:0] prev_q;
  logic [2*W-1:0] pair;
  assign pair = {inv_word, prev_q};
  logic [$clog2(W)-1:0] off_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) prev_q <= '0;
    else if (rx_word_valid) prev_q <= inv_word;
  end

  function automatic logic [W-1:0] win(input logic [2*W-1:0] p, input logic [$clog2(W)-1:0] o);
    win = p[o +: W];
  endfunction

  // pattern search over all offsets
  logic [W-1:0] hit;
  for (genvar g = 0; g < W; g++) begin : g_srch
    assign hit[g] = (win(pair, $clog2(W)'(g)) == pat_q[W-1:0]);
  end
  logic [$clog2(W)-1:0] hit_off;
  always_comb begin
    hit_off = '0;
    for (int i = W - 1; i >= 0; i--) begin
      if (hit[i]) hit_off = i[$clog2(W)-1:0];
    end
  end
  logic cur_hit;
  assign cur_hit = hit[off_q];
  logic may_align;
  assign may_align = mode == rx_pcs_pkg::align_auto || (mode == rx_pcs_pkg::align_manual && ctl_q[2]);

  rx_pcs_pkg::al_state_t st_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q  <= rx_pcs_pkg::al_search;
      off_q <= '0;
    end else if (slip_rise) begin
      off_q <= (off_q == $clog2(W)'(W - 1)) ? '0 : off_q + 1'b1;
      st_q  <= rx_pcs_pkg::al_search;
    end else if (rx_word_valid) begin
      case (st_q)
        rx_pcs_pkg::al_search: begin
          if (may_align && |hit) begin
            off_q <= hit_off;
            st_q  <= rx_pcs_pkg::al_locked;
          end
        end
        rx_pcs_pkg::al_locked: begin
          if (mode == rx_pcs_pkg::align_bitslip) st_q <= rx_pcs_pkg::al_search;
        end
        default: st_q <= rx_pcs_pkg::al_search;
      endcase
    end
  end

  // aligned outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      aligned_word       <= '0;
      align_locked       <= 1'b0;
      pattern_found_flag <= 1'b0;
      ctrl_group_flag    <= 1'b0;
    end else begin
      aligned_word       <= win(pair, off_q);
      align_locked       <= st_q == rx_pcs_pkg::al_locked && mode != rx_pcs_pkg::align_bitslip;
      pattern_found_flag <= rx_word_valid && cur_hit;
      ctrl_group_flag    <= rx_word_valid && rx_is_ctrl_in;
    end
  end

  // run length tracking on the serial stream, lsb first
  logic       last_bit_q, run_over;
  logic [7:0] run_q, run_n;
  always_comb begin
    run_n    = run_q;
    run_over = 1'b0;
    for (int i = 0; i < W; i++) begin
      if (i == 0) run_n = (inv_word[0] == last_bit_q) ? run_q + 8'h01 : 8'h01;
      else run_n = (inv_word[i] == inv_word[i-1]) ? run_n + 8'h01 : 8'h01;
      if (run_n == 8'hFF) run_n = 8'hFE;
      if (run_n > rlvth_q[7:0]) run_over = 1'b1;
    end
  end
  logic [1:0] hold_len;
  assign hold_len = ctrl_q[rx_pcs_pkg::c_bytedes] ? rx_pcs_pkg::hold_bd : rx_pcs_pkg::hold_nobd;
  logic rlv_ev;
  assign rlv_ev = rx_word_valid && run_over;
  logic [1:0] rlv_cnt_q, full_cnt_q, empty_cnt_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_bit_q <= 1'b0;
      run_q      <= 8'h00;
    end else if (rx_word_valid) begin
      last_bit_q <= inv_word[W-1];
      run_q      <= run_n;
    end
  end

  // stretched pulses: hold for at least hold_len cycles
  function automatic logic [1:0] stretch(input logic ev, input logic [1:0] c, input logic [1:0] h);
    stretch = ev ? h : (c != 2'h0 ? c - 2'h1 : 2'h0);
  endfunction
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rlv_cnt_q   <= 2'h0;
      full_cnt_q  <= 2'h0;
      empty_cnt_q <= 2'h0;
    end else begin
      rlv_cnt_q   <= stretch(rlv_ev, rlv_cnt_q, hold_len);
      full_cnt_q  <= stretch(rm_full_in, full_cnt_q, hold_len);
      empty_cnt_q <= stretch(rm_empty_in, empty_cnt_q, hold_len);
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_length_viol       <= 1'b0;
      ratematch_full        <= 1'b0;
      ratematch_empty       <= 1'b0;
      ratematch_insert_flag <= 1'b0;
      ratematch_delete_flag <= 1'b0;
    end else begin
      run_length_viol       <= rlv_ev || rlv_cnt_q > 2'h1;
      ratematch_full        <= rm_full_in || full_cnt_q > 2'h1;
      ratematch_empty       <= rm_empty_in || empty_cnt_q > 2'h1;
      ratematch_insert_flag <= rm_insert_ev && ctrl_q[rx_pcs_pkg::c_ratematch];
      ratematch_delete_flag <= rm_delete_ev && ctrl_q[rx_pcs_pkg::c_ratematch];
    end
  end

  // domain reporting
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      align_status_dom <= 2'(rx_pcs_pkg::dom_rec);
      ratematch_dom    <= 2'(rx_pcs_pkg::dom_tx);
    end else begin
      if (ctrl_q[rx_pcs_pkg::c_corerd]) align_status_dom <= 2'(rx_pcs_pkg::dom_rdclk);
      else if (ctrl_q[rx_pcs_pkg::c_bonded]) align_status_dom <= 2'(rx_pcs_pkg::dom_core);
      else if (ctrl_q[rx_pcs_pkg::c_ratematch]) align_status_dom <= 2'(rx_pcs_pkg::dom_tx);
      else align_status_dom <= 2'(rx_pcs_pkg::dom_rec);
      ratematch_dom <= ctrl_q[rx_pcs_pkg::c_bonded] ? 2'(rx_pcs_pkg::dom_core) : 2'(rx_pcs_pkg::dom_tx);
    end
  end

  // interrupts: sticky, write one to clear, set wins
  logic [n_irq_w-1:0] ev;
  assign ev = {ratematch_delete_flag, ratematch_insert_flag, ratematch_empty,
               ratematch_full, run_length_viol, pattern_found_flag};
  logic wr;
  assign wr = acc && pwrite;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) irq_st_q <= '0;
    else begin
      for (int i = 0; i < n_irq_w; i++) begin
        if (ev[i]) irq_st_q[i] <= 1'b1;
        else if (wr && paddr == rx_pcs_pkg::irq_off && pwdata[i]) irq_st_q[i] <= 1'b0;
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) irq <= 1'b0;
    else irq <= |(irq_st_q & mask_q);
  end

  // apb registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q  <= rx_pcs_pkg::ctrl_rst;
      rlvth_q <= rx_pcs_pkg::rlvth_rst;
      pat_q   <= rx_pcs_pkg::pat_rst;
      mask_q  <= '0;
    end else if (wr) begin
      case (paddr)
        rx_pcs_pkg::ctrl_off:  ctrl_q  <= pwdata;
        rx_pcs_pkg::rlvth_off: rlvth_q <= pwdata;
        rx_pcs_pkg::pat_off:   pat_q   <= pwdata;
        rx_pcs_pkg::mask_off:  mask_q  <= pwdata[n_irq_w-1:0];
        default: ;
      endcase
    end
  end
  logic mapped;
  always_comb begin
    case (paddr)
      rx_pcs_pkg::ctrl_off, rx_pcs_pkg::status_off, rx_pcs_pkg::irq_off, rx_pcs_pkg::mask_off,
      rx_pcs_pkg::rlvth_off, rx_pcs_pkg::pat_off: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      if (psel && !penable && !pwrite) begin
        case (paddr)
          rx_pcs_pkg::ctrl_off:   prdata <= ctrl_q;
          rx_pcs_pkg::status_off: prdata <= {24'h0, ratematch_empty, ratematch_full, st_q == rx_pcs_pkg::al_locked,
                                             1'b0, 4'(off_q)};
          rx_pcs_pkg::irq_off:    prdata <= {26'h0, irq_st_q};
          rx_pcs_pkg::mask_off:   prdata <= {26'h0, mask_q};
          rx_pcs_pkg::rlvth_off:  prdata <= rlvth_q;
          rx_pcs_pkg::pat_off:    prdata <= pat_q;
          default:                prdata <= 32'h0000_0000;
        endcase
      end
    end
  end
  // assertions
  sequence s_slip_edge;
    slip_rise;
  endsequence
  a_slip_moves_one: assert property (@(posedge pclk) disable iff (!presetn)
    s_slip_edge |=> off_q == (($past(off_q) == $clog2(W)'(W - 1)) ? '0 : $past(off_q) + 1'b1))
    else $error("slip did not move boundary by one");
  a_lock_not_bitslip: assert property (@(posedge pclk) disable iff (!presetn)
    mode == rx_pcs_pkg::align_bitslip |=> !align_locked)
    else $error("lock shown in bitslip mode");
  a_pattern_found: assert property (@(posedge pclk) disable iff (!presetn)
    rx_word_valid && cur_hit |=> pattern_found_flag)
    else $error("pattern found not flagged");
  a_rlv_min_width: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(run_length_viol) |-> run_length_viol[*2])
    else $error("violation pulse too short");
  a_rlv_cause: assert property (@(posedge pclk) disable iff (!presetn)
    rlv_ev |=> run_length_viol)
    else $error("violation not reported");
  a_polarity_inv: assert property (@(posedge pclk) disable iff (!presetn)
    ctl_q[1] |-> inv_word == ~rx_word_in)
    else $error("polarity inversion wrong");
  a_full_hold: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(ratematch_full) && ctrl_q[rx_pcs_pkg::c_bytedes] |-> ratematch_full[*3])
    else $error("full flag too short");
  a_empty_cause: assert property (@(posedge pclk) disable iff (!presetn)
    rm_empty_in |=> ratematch_empty)
    else $error("empty not flagged");
  a_ins_flag: assert property (@(posedge pclk) disable iff (!presetn)
    rm_insert_ev && ctrl_q[rx_pcs_pkg::c_ratematch] |=> ratematch_insert_flag)
    else $error("insert not flagged");
  a_del_flag: assert property (@(posedge pclk) disable iff (!presetn)
    rm_delete_ev && ctrl_q[rx_pcs_pkg::c_ratematch] |=> ratematch_delete_flag)
    else $error("delete not flagged");
  a_ctrl_ident: assert property (@(posedge pclk) disable iff (!presetn)
    rx_word_valid |=> ctrl_group_flag == $past(rx_is_ctrl_in))
    else $error("control identifier wrong");
  a_manual_gate: assert property (@(posedge pclk) disable iff (!presetn)
    mode == rx_pcs_pkg::align_manual && !ctl_q[2] && st_q == rx_pcs_pkg::al_search && !slip_rise
    |=> st_q == rx_pcs_pkg::al_search)
    else $error("manual mode aligned without enable");
  a_sync_delay: assert property (@(posedge pclk) disable iff (!presetn)
    s2_q[1] == s3_q[1] |=> ctl_q[1] == $past(s3_q[1]))
    else $error("synchroniser filter wrong");
  a_dom_bonded: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_q[rx_pcs_pkg::c_bonded] |=> ratematch_dom == 2'(rx_pcs_pkg::dom_core))
    else $error("rate match domain wrong");
  a_dom_align: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_q[rx_pcs_pkg::c_corerd] |=> align_status_dom == 2'(rx_pcs_pkg::dom_rdclk))
    else $error("align domain wrong");
endmodule
`default_nettype wire

// ==== tb/fabric_ctrl_model.sv ====
// fabric user logic model: drives the async alignment controls
// assumes: pclk is the parallel clock; commands come from the bench
`timescale 1ns/1ps
`default_nettype none
module fabric_ctrl_model #(
  parameter int HOLD = 3
) (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // bench commands
  input  wire logic slip_cmd,
  input  wire logic pol_cmd,
  input  wire logic man_cmd,
  // pins toward the block
  output logic      bitslip_req,
  output var logic  polarity_inv,
  output var logic  manual_align_enable_in
);
  int slip_cnt;
  int pol_age;
  // slip request high for HOLD cycles, then low for at least HOLD+1 cycles
  assign bitslip_req = (slip_cnt > HOLD);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slip_cnt <= 0;
    end else if (slip_cnt == 0 && slip_cmd) begin
      slip_cnt <= 2 * HOLD;
    end else if (slip_cnt != 0) begin
      slip_cnt <= slip_cnt - 1;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pol_age      <= 0;
      polarity_inv <= 1'h0;
    end else if (pol_cmd != polarity_inv && pol_age >= HOLD) begin
      pol_age      <= 0;
      polarity_inv <= pol_cmd;
    end else if (pol_age < HOLD) begin
      pol_age <= pol_age + 1;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      manual_align_enable_in <= 1'h0;
    end else begin
      manual_align_enable_in <= man_cmd;
    end
  end
endmodule
`default_nettype wire

// ==== tb/rx_pcs_align_ratematch_status_test.sv ====
// testbench: apb register checks and receive status scenarios
// assumes: fabric_ctrl_model drives the async controls
`timescale 1ns/1ps
`default_nettype none
module rx_pcs_align_ratematch_status_test;
  localparam int W = 10;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [9:0]  rx_word_in, aligned_word;
  logic        rx_word_valid, rx_is_ctrl_in, slip_cmd, pol_cmd, man_cmd;
  logic        bitslip_req, polarity_inv, manual_align_enable_in, align_locked, irq;
  logic        pattern_found_flag, run_length_viol, ratematch_insert_flag, ratematch_delete_flag;
  logic        ratematch_full, ratematch_empty, ctrl_group_flag;
  logic [1:0]  align_status_dom, ratematch_dom;
  logic [3:0]  ev;
  wire         rm_insert_ev, rm_delete_ev, rm_full_in, rm_empty_in;
  wire  [5:0]  mon = {ratematch_delete_flag, ratematch_insert_flag, run_length_viol,
                      ratematch_full, ratematch_empty, pattern_found_flag};
  int          fail_count, checks, best;
  assign {rm_delete_ev, rm_insert_ev, rm_full_in, rm_empty_in} = ev;

  rx_pcs_align_ratematch_status #(.W(W)) i_rx_pcs_align_ratematch_status (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .rx_word_in, .rx_word_valid, .rx_is_ctrl_in, .rm_insert_ev, .rm_delete_ev, .rm_full_in,
    .rm_empty_in, .bitslip_req, .polarity_inv, .manual_align_enable_in, .aligned_word,
    .align_locked, .pattern_found_flag, .run_length_viol, .ratematch_insert_flag,
    .ratematch_delete_flag, .ratematch_full, .ratematch_empty, .ctrl_group_flag,
    .align_status_dom, .ratematch_dom, .irq);
  fabric_ctrl_model #(.HOLD(3)) i_fabric_ctrl_model (
    .pclk, .presetn, .slip_cmd, .pol_cmd, .man_cmd, .bitslip_req, .polarity_inv,
    .manual_align_enable_in);

  initial begin
    pclk = 1'h0;
    forever #2 pclk = ~pclk;
  end
  task automatic report_and_stop();
    $display("counts: checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'h1;
    penable <= 1'h0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 16);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
    if (pready !== 1'h1) begin
      fail_count++;
      report_and_stop();
    end
  endtask
  task automatic word(input logic [9:0] w, input logic k);
    @(posedge pclk);
    rx_word_in    <= w;
    rx_is_ctrl_in <= k;
  endtask
  // fire events for one cycle, send zeros words, then measure longest high run
  task automatic run_len(input int idx, input logic [3:0] fire, input int zeros);
    int cur;
    cur  = 0;
    best = 0;
    @(posedge pclk);
    ev         <= fire;
    rx_word_in <= (zeros > 0) ? 10'h000 : 10'h155;
    for (int i = 1; i <= 40; i++) begin
      @(posedge pclk);
      ev         <= 4'h0;
      rx_word_in <= (i < zeros) ? 10'h000 : 10'h155;
      #1;
      cur  = (mon[idx] === 1'h1) ? cur + 1 : 0;
      best = (cur > best) ? cur : best;
    end
  endtask
  task automatic t_regs();
    logic [7:0]  offs[6] = '{rx_pcs_pkg::ctrl_off, rx_pcs_pkg::rlvth_off, rx_pcs_pkg::pat_off,
                             rx_pcs_pkg::rmlvl_off, rx_pcs_pkg::mask_off, rx_pcs_pkg::irq_off};
    logic [31:0] exps[6] = '{rx_pcs_pkg::ctrl_rst, rx_pcs_pkg::rlvth_rst, rx_pcs_pkg::pat_rst,
                             rx_pcs_pkg::rmlvl_rst, 32'h0, 32'h0};
    for (int i = 0; i < 6; i++) begin
      apb(1'h0, offs[i], 32'h0);
      chk(rd, exps[i]);
    end
    apb(1'h0, 8'h1C, 32'h0);
    chk(err, 1'h1);
    chk(rd, 32'h0);
    $display("test regs done");
  endtask
  task automatic t_ctrl();
    word(10'h155, 1'h1);
    @(posedge pclk);
    #1;
    chk(ctrl_group_flag, 1'h1);
    word(10'h155, 1'h0);
    @(posedge pclk);
    #1;
    chk(ctrl_group_flag, 1'h0);
    $display("test ctrl done");
  endtask
  task automatic t_pattern();
    word(rx_pcs_pkg::pat_rst[9:0], 1'h0);
    run_len(0, 4'h0, 0);
    chk(best != 0, 1'h1);
    pol_cmd <= 1'h1;
    repeat (12) word(10'h155, 1'h0);
    word(~rx_pcs_pkg::pat_rst[9:0], 1'h0);
    run_len(0, 4'h0, 0);
    chk(best != 0, 1'h1);
    word(rx_pcs_pkg::pat_rst[9:0], 1'h0);
    run_len(0, 4'h0, 0);
    chk(best, 0);
    pol_cmd <= 1'h0;
    repeat (12) word(10'h155, 1'h0);
    $display("test pattern done");
  endtask
  task automatic t_rlv();
    apb(1'h1, rx_pcs_pkg::rlvth_off, 32'h0B);
    run_len(3, 4'h0, 1);
    chk(best, 0);
    apb(1'h1, rx_pcs_pkg::rlvth_off, 32'h0A);
    run_len(3, 4'h0, 1);
    chk(best >= rx_pcs_pkg::hold_nobd, 1'h1);
    apb(1'h1, rx_pcs_pkg::rlvth_off, rx_pcs_pkg::rlvth_rst);
    apb(1'h1, rx_pcs_pkg::ctrl_off, 32'h60);
    run_len(3, 4'h0, 3);
    chk(best >= rx_pcs_pkg::hold_bd, 1'h1);
    apb(1'h0, rx_pcs_pkg::irq_off, 32'h0);
    chk(rd[rx_pcs_pkg::i_rlv], 1'h1);
    chk(irq, 1'h0);
    apb(1'h1, rx_pcs_pkg::mask_off, 32'h1 << rx_pcs_pkg::i_rlv);
    repeat (2) @(posedge pclk);
    #1;
    chk(irq, 1'h1);
    apb(1'h1, rx_pcs_pkg::irq_off, 32'h1 << rx_pcs_pkg::i_rlv);
    repeat (2) @(posedge pclk);
    #1;
    chk(irq, 1'h0);
    apb(1'h0, rx_pcs_pkg::irq_off, 32'h0);
    chk(rd[rx_pcs_pkg::i_rlv], 1'h0);
    apb(1'h1, rx_pcs_pkg::mask_off, 32'h0);
    apb(1'h1, rx_pcs_pkg::ctrl_off, rx_pcs_pkg::ctrl_rst);
    $display("test run length done");
  endtask
  task automatic t_rm();
    run_len(4, 4'h4, 0);
    chk(best, 0);
    for (int b = 0; b < 2; b++) begin
      apb(1'h1, rx_pcs_pkg::ctrl_off, b ? 32'h64 : 32'h44);
      run_len(4, 4'h4, 0);
      chk(best, 1);
      run_len(5, 4'h8, 0);
      chk(best, 1);
      run_len(2, 4'h2, 0);
      chk(best >= (b ? rx_pcs_pkg::hold_bd : rx_pcs_pkg::hold_nobd), 1'h1);
      run_len(1, 4'h1, 0);
      chk(best >= (b ? rx_pcs_pkg::hold_bd : rx_pcs_pkg::hold_nobd), 1'h1);
    end
    $display("test rate match done");
  endtask
  task automatic t_dom();
    logic [31:0] cfg[4] = '{32'h44, 32'h40, 32'h48, 32'h50};
    logic [1:0]  ea[4]  = '{rx_pcs_pkg::dom_tx, rx_pcs_pkg::dom_rec, rx_pcs_pkg::dom_core, rx_pcs_pkg::dom_rdclk};
    logic [1:0]  er[4]  = '{rx_pcs_pkg::dom_tx, rx_pcs_pkg::dom_tx, rx_pcs_pkg::dom_core, rx_pcs_pkg::dom_tx};
    for (int i = 0; i < 4; i++) begin
      apb(1'h1, rx_pcs_pkg::ctrl_off, cfg[i]);
      repeat (2) @(posedge pclk);
      #1;
      chk(align_status_dom, ea[i]);
      chk(ratematch_dom, er[i]);
    end
    $display("test domains done");
  endtask
  task automatic t_slip();
    logic [3:0] o;
    apb(1'h1, rx_pcs_pkg::ctrl_off, 32'h42);
    for (int i = 0; i < 2; i++) begin
      apb(1'h0, rx_pcs_pkg::status_off, 32'h0);
      o = rd[3:0];
      @(posedge pclk);
      slip_cmd <= 1'h1;
      @(posedge pclk);
      slip_cmd <= 1'h0;
      repeat (16) @(posedge pclk);
      apb(1'h0, rx_pcs_pkg::status_off, 32'h0);
      chk(rd[3:0], (o == W - 1) ? 4'h0 : o + 4'h1);
    end
    repeat (4) word(rx_pcs_pkg::pat_rst[9:0], 1'h0);
    repeat (3) word(10'h155, 1'h0);
    #1;
    chk(align_locked, 1'h0);
    $display("test bit slip done");
  endtask
  // manual mode: no lock while the enable is low, lock at offset 0 once it is high
  task automatic t_manual();
    apb(1'h1, rx_pcs_pkg::ctrl_off, 32'h41);
    repeat (4) word(rx_pcs_pkg::pat_rst[9:0], 1'h0);
    repeat (2) word(10'h155, 1'h0);
    #1;
    chk(align_locked, 1'h0);
    @(posedge pclk);
    man_cmd <= 1'h1;
    repeat (8) word(10'h155, 1'h0);
    repeat (4) word(rx_pcs_pkg::pat_rst[9:0], 1'h0);
    repeat (2) word(10'h155, 1'h0);
    #1;
    chk(align_locked, 1'h1);
    chk(aligned_word, rx_pcs_pkg::pat_rst[9:0]);
    @(posedge pclk);
    man_cmd <= 1'h0;
    $display("test manual align done");
  endtask

  initial begin
    presetn       = 1'h0;
    psel          = 1'h0;
    penable       = 1'h0;
    pwrite        = 1'h0;
    paddr         = 8'h00;
    pwdata        = 32'h0;
    rx_word_in    = 10'h155;
    rx_word_valid = 1'h0;
    rx_is_ctrl_in = 1'h0;
    ev            = 4'h0;
    slip_cmd      = 1'h0;
    pol_cmd       = 1'h0;
    man_cmd       = 1'h0;
    fail_count    = 0;
    checks        = 0;
    repeat (12) @(posedge pclk);
    presetn       <= 1'h1;
    rx_word_valid <= 1'h1;
    t_regs();
    t_ctrl();
    t_pattern();
    t_rlv();
    t_rm();
    t_dom();
    t_slip();
    t_manual();
    report_and_stop();
  end
endmodule
`default_nettype wire
